// file: tad_pkg.sv
// Function
// RULE1: The host supplies the channel-select and reference-mode bits serially, and the device sets its input multiplexer and reference routing from them.
// RULE2: With the reference-mode bit high, codes 000, 010, 110 and 111 select temperature diode 0, battery, auxiliary input and temperature diode 1, with all panel drivers off.
// RULE3: In single-ended mode, 001 measures Y on X+ with Y drivers on, 011 measures Z1 on X+, 100 measures Z2 on Y- with X- and Y+ on, and 101 measures X on Y+ with X drivers on.
// RULE4: With the reference-mode bit low, 001 uses reference Y+/Y- driving Y+ and Y-, 011 and 100 use Y+/X- driving Y+ and X-, and 101 uses X+/X- driving X+ and X-.
// RULE5: With the reference-mode bit low, the reference inputs connect straight to the driven panel plates so the result is ratiometric.
// RULE6: The internal 2.5V reference is on when the reference power bit is 1 and off when it is 0.
// RULE7: After power-up the host sends a control byte with the reference power bit cleared so the internal reference is surely off.
// RULE8: One output code step weighs the reference voltage divided by 4096, a twelve-bit result.
// RULE9: The host uses differential mode only with the supply as positive reference, and single-ended mode with a precision reference for non-ratiometric work.
// RULE10: The battery divide-by-4 network is on only while the battery code is being sampled.
// RULE11: With the reference-mode bit low and an unlisted channel code, all panel drivers stay off and the result is undefined.
package tad_pkg;

  // ***************************************************
  // Register port
  // ***************************************************
  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned DATA_W     = 8;
  localparam logic [3:0]  OFS_CTRL   = 4'h0;
  localparam logic [3:0]  OFS_ROUTE  = 4'h1;
  localparam logic [3:0]  OFS_DRIVE  = 4'h2;

  // ***************************************************
  // Control byte fields
  // ***************************************************
  localparam int unsigned CB_START   = 7;
  localparam int unsigned CB_CHAN_HI = 6;
  localparam int unsigned CB_CHAN_LO = 4;
  localparam int unsigned CB_RES8    = 3;
  localparam int unsigned CB_REFMODE = 2;
  localparam int unsigned CB_REFPWR  = 1;
  localparam int unsigned CB_ADCPWR  = 0;
  // Reference power bit clear after reset: internal reference off
  localparam logic [7:0]  CTRL_RESET = 8'h00;

  // ***************************************************
  // Channel codes
  // ***************************************************
  localparam logic [2:0] CH_TEMP0 = 3'h0;
  localparam logic [2:0] CH_YPOS  = 3'h1;
  localparam logic [2:0] CH_VBAT  = 3'h2;
  localparam logic [2:0] CH_Z1    = 3'h3;
  localparam logic [2:0] CH_Z2    = 3'h4;
  localparam logic [2:0] CH_XPOS  = 3'h5;
  localparam logic [2:0] CH_AUX   = 3'h6;
  localparam logic [2:0] CH_TEMP1 = 3'h7;

  // ***************************************************
  // Converter resolution
  // ***************************************************
  localparam int unsigned RESULT_BITS = 12;                 // [RULE8]
  localparam int unsigned LSB_DIVISOR = 1 << RESULT_BITS;   // [RULE8]

  // Positive input of the converter
  typedef enum logic [2:0] {
    TAD_IN_TEMP0,
    TAD_IN_TEMP1,
    TAD_IN_VBAT,
    TAD_IN_AUX,
    TAD_IN_XP,
    TAD_IN_YP,
    TAD_IN_YN
  } tad_in_t;

  // Reference sources
  typedef enum logic [1:0] {
    TAD_RP_PIN,
    TAD_RP_YP,
    TAD_RP_XP
  } tad_refp_t;

  typedef enum logic [1:0] {
    TAD_RN_GND,
    TAD_RN_YN,
    TAD_RN_XN
  } tad_refn_t;

endpackage

// file: tad_decode.sv
`timescale 1ns/10ps
`default_nettype none
module tad_decode (
  input  wire logic         [2:0] chan,
  input  wire logic               ser_mode,
  output tad_pkg::tad_in_t        in_sel,
  output tad_pkg::tad_refp_t      ref_pos,
  output tad_pkg::tad_refn_t      ref_neg,
  output logic                    drv_xp,
  output logic                    drv_xn,
  output logic                    drv_yp,
  output logic                    drv_yn,
  output logic                    vbat_sel
);

  always_comb begin
    in_sel   = tad_pkg::TAD_IN_TEMP0;
    ref_pos  = tad_pkg::TAD_RP_PIN;
    ref_neg  = tad_pkg::TAD_RN_GND;
    drv_xp   = 1'b0;
    drv_xn   = 1'b0;
    drv_yp   = 1'b0;
    drv_yn   = 1'b0;
    vbat_sel = 1'b0;
    case (chan)                                           // [RULE1]
      tad_pkg::CH_TEMP0: begin
        in_sel = tad_pkg::TAD_IN_TEMP0;                   // [RULE2]
      end
      tad_pkg::CH_VBAT: begin
        in_sel   = tad_pkg::TAD_IN_VBAT;                  // [RULE2]
        vbat_sel = 1'b1;
      end
      tad_pkg::CH_AUX: begin
        in_sel = tad_pkg::TAD_IN_AUX;                     // [RULE2]
      end
      tad_pkg::CH_TEMP1: begin
        in_sel = tad_pkg::TAD_IN_TEMP1;                   // [RULE2]
      end
      tad_pkg::CH_YPOS: begin
        in_sel = tad_pkg::TAD_IN_XP;                      // [RULE3]
        drv_yp = 1'b1;
        drv_yn = 1'b1;                                    // [RULE4]
        if (!ser_mode) begin
          ref_pos = tad_pkg::TAD_RP_YP;                   // [RULE5]
          ref_neg = tad_pkg::TAD_RN_YN;
        end
      end
      tad_pkg::CH_Z1, tad_pkg::CH_Z2: begin
        // Enum target: explicit branches keep both sides of one type
        if (chan == tad_pkg::CH_Z1) begin
          in_sel = tad_pkg::TAD_IN_XP;                    // [RULE3]
        end else begin
          in_sel = tad_pkg::TAD_IN_YN;
        end
        drv_yp = 1'b1;
        drv_xn = 1'b1;                                    // [RULE4]
        if (!ser_mode) begin
          ref_pos = tad_pkg::TAD_RP_YP;                   // [RULE5]
          ref_neg = tad_pkg::TAD_RN_XN;
        end
      end
      tad_pkg::CH_XPOS: begin
        in_sel = tad_pkg::TAD_IN_YP;                      // [RULE3]
        drv_xp = 1'b1;
        drv_xn = 1'b1;                                    // [RULE4]
        if (!ser_mode) begin
          ref_pos = tad_pkg::TAD_RP_XP;                   // [RULE5]
          ref_neg = tad_pkg::TAD_RN_XN;
        end
      end
      default: begin
        in_sel = tad_pkg::TAD_IN_TEMP0;
      end
    endcase
    // Non-panel codes keep drivers off in either mode
  end

endmodule
`default_nettype wire

// file: tad_mux_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module tad_mux_ctrl (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic [tad_pkg::ADDR_W-1:0]   addr,
  input  wire logic [tad_pkg::DATA_W-1:0]   wdata,
  input  wire logic                         wr,
  input  wire logic                         rd,
  input  wire logic                         sample_active,
  output logic      [tad_pkg::DATA_W-1:0]   rdata,
  output tad_pkg::tad_in_t                  in_sel,
  output tad_pkg::tad_refp_t                ref_pos,
  output tad_pkg::tad_refn_t                ref_neg,
  output logic                              drv_xp,
  output logic                              drv_xn,
  output logic                              drv_yp,
  output logic                              drv_yn,
  output logic                              ref_int_en,
  output logic                              vbat_div_en,
  output logic                              res_8bit,
  output logic                              adc_pwr_keep
);

  // ***************************************************
  // Control byte
  // ***************************************************
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;

  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr && addr == tad_pkg::OFS_CTRL && wdata[tad_pkg::CB_START]) begin
      ctrl_next = wdata;                                  // [RULE1]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= tad_pkg::CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ***************************************************
  // Decode
  // ***************************************************
  tad_pkg::tad_in_t   dec_in;
  tad_pkg::tad_refp_t dec_rp;
  tad_pkg::tad_refn_t dec_rn;
  logic dec_xp;
  logic dec_xn;
  logic dec_yp;
  logic dec_yn;
  logic dec_vbat;

  tad_decode u_decode (
    .chan     (ctrl_reg[tad_pkg::CB_CHAN_HI:tad_pkg::CB_CHAN_LO]),
    .ser_mode (ctrl_reg[tad_pkg::CB_REFMODE]),
    .in_sel   (dec_in),
    .ref_pos  (dec_rp),
    .ref_neg  (dec_rn),
    .drv_xp   (dec_xp),
    .drv_xn   (dec_xn),
    .drv_yp   (dec_yp),
    .drv_yn   (dec_yn),
    .vbat_sel (dec_vbat)
  );

  // ***************************************************
  // Registered outputs
  // ***************************************************
  tad_pkg::tad_in_t   in_sel_reg;
  tad_pkg::tad_refp_t ref_pos_reg;
  tad_pkg::tad_refn_t ref_neg_reg;
  logic [3:0] drv_reg;
  logic [3:0] drv_next;
  logic       ref_int_reg;
  logic       ref_int_next;
  logic       vbat_div_reg;
  logic       vbat_div_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  always_comb begin
    drv_next      = {dec_xp, dec_xn, dec_yp, dec_yn};     // [RULE3] [RULE4] [RULE11]
    ref_int_next  = ctrl_reg[tad_pkg::CB_REFPWR];        // [RULE6]
    // Divider draws battery current, so only during the acquire window
    vbat_div_next = dec_vbat && sample_active;           // [RULE10]
    rdata_next    = 8'h00;
    if (rd) begin
      case (addr)
        tad_pkg::OFS_CTRL:  rdata_next = ctrl_reg;
        tad_pkg::OFS_ROUTE: rdata_next = {1'b0, in_sel_reg, ref_pos_reg, ref_neg_reg};
        tad_pkg::OFS_DRIVE: rdata_next = {2'h0, vbat_div_reg, ref_int_reg, drv_reg};
        default:            rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      in_sel_reg   <= tad_pkg::TAD_IN_TEMP0;
      ref_pos_reg  <= tad_pkg::TAD_RP_PIN;
      ref_neg_reg  <= tad_pkg::TAD_RN_GND;
      drv_reg      <= 4'h0;
      ref_int_reg  <= 1'b0;
      vbat_div_reg <= 1'b0;
      rdata_reg    <= 8'h00;
    end else begin
      in_sel_reg   <= dec_in;                             // [RULE2]
      ref_pos_reg  <= dec_rp;                             // [RULE5]
      ref_neg_reg  <= dec_rn;
      drv_reg      <= drv_next;
      ref_int_reg  <= ref_int_next;
      vbat_div_reg <= vbat_div_next;
      rdata_reg    <= rdata_next;
    end
  end

  assign rdata        = rdata_reg;
  assign in_sel       = in_sel_reg;
  assign ref_pos      = ref_pos_reg;
  assign ref_neg      = ref_neg_reg;
  assign drv_xp       = drv_reg[3];
  assign drv_xn       = drv_reg[2];
  assign drv_yp       = drv_reg[1];
  assign drv_yn       = drv_reg[0];
  assign ref_int_en   = ref_int_reg;
  assign vbat_div_en  = vbat_div_reg;
  assign res_8bit     = ctrl_reg[tad_pkg::CB_RES8];
  assign adc_pwr_keep = ctrl_reg[tad_pkg::CB_ADCPWR];

endmodule
`default_nettype wire

// file: tad_mux_ctrl_properties.sv
`timescale 1ns/10ps
`default_nettype none
module tad_mux_ctrl_properties (
  input wire logic                [3:0] addr,
  input wire logic                      clk,
  input wire logic                      rst,
  input wire logic                [7:0] wdata,
  input wire logic                      wr,
  input wire logic                      rd,
  input wire logic                      sample_active,
  input wire logic                [7:0] rdata,
  input wire tad_pkg::tad_in_t          in_sel,
  input wire tad_pkg::tad_refp_t        ref_pos,
  input wire tad_pkg::tad_refn_t        ref_neg,
  input wire logic                      drv_xp,
  input wire logic                      drv_xn,
  input wire logic                      drv_yp,
  input wire logic                      drv_yn,
  input wire logic                      ref_int_en,
  input wire logic                      vbat_div_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire       ctl = wr && (addr == 4'h0) && wdata[7];
  wire [2:0] ch  = wdata[6:4];
  wire [3:0] drv = {drv_xp, drv_xn, drv_yp, drv_yn};
  property p_rd_idle; !rd |=> rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_refpwr; ctl |=> ##1 ref_int_en == $past(wdata[1], 2); endproperty
  a_refpwr: assert property (p_refpwr) else $error("ref enable wrong");
  property p_off; ctl && (ch inside {3'h0, 3'h2, 3'h6, 3'h7}) |=> ##1 drv == 4'h0; endproperty
  a_off: assert property (p_off) else $error("drivers on");
  property p_y; ctl && ch == 3'h1 |=> ##1 drv == 4'h3 && in_sel == tad_pkg::TAD_IN_XP;
  endproperty
  a_y: assert property (p_y) else $error("y setup wrong");
  property p_z; ctl && (ch == 3'h3 || ch == 3'h4) |=> ##1 drv == 4'h6; endproperty
  a_z: assert property (p_z) else $error("z drivers wrong");
  property p_x; ctl && ch == 3'h5 |=> ##1 drv == 4'hC && in_sel == tad_pkg::TAD_IN_YP;
  endproperty
  a_x: assert property (p_x) else $error("x setup wrong");
  property p_ratio; ctl && !wdata[2] && ch == 3'h5
    |=> ##1 ref_pos == tad_pkg::TAD_RP_XP && ref_neg == tad_pkg::TAD_RN_XN; endproperty
  a_ratio: assert property (p_ratio) else $error("ratio ref wrong");
  property p_ser_ref; ctl && wdata[2]
    |=> ##1 ref_pos == tad_pkg::TAD_RP_PIN && ref_neg == tad_pkg::TAD_RN_GND; endproperty
  a_ser_ref: assert property (p_ser_ref) else $error("single ref wrong");
  property p_vbat;
    vbat_div_en == ($past(sample_active) && in_sel == tad_pkg::TAD_IN_VBAT);
  endproperty
  a_vbat: assert property (p_vbat) else $error("divider on idle");
  c_diff: cover property (ctl && ch == 3'h1 && !wdata[2]);
  c_vbat: cover property ($rose(vbat_div_en));
  c_ref: cover property ($rose(ref_int_en));
endmodule
`default_nettype wire

// file: tad_host.sv
`timescale 1ns/10ps
`default_nettype none
module tad_host (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output logic      [3:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd
);
  initial begin
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // Released lines show the inverse so a stale value never passes
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic get(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    @(posedge clk);
    d = rdata;
  endtask
endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk, rst, sample_active, wr, rd;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, rv, cur, lfsr;
  tad_pkg::tad_in_t in_sel;
  tad_pkg::tad_refp_t ref_pos;
  tad_pkg::tad_refn_t ref_neg;
  logic drv_xp, drv_xn, drv_yp, drv_yn, ref_int_en, vbat_div_en, res_8bit, adc_pwr_keep;
  int err_count, samples_checked;
  localparam logic [2:0] IN_MAP [8] = '{tad_pkg::TAD_IN_TEMP0, tad_pkg::TAD_IN_XP,
    tad_pkg::TAD_IN_VBAT, tad_pkg::TAD_IN_XP, tad_pkg::TAD_IN_YN, tad_pkg::TAD_IN_YP,
    tad_pkg::TAD_IN_AUX, tad_pkg::TAD_IN_TEMP1};
  tad_mux_ctrl u_tad_mux_ctrl (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .sample_active(sample_active), .rdata(rdata), .in_sel(in_sel),
    .ref_pos(ref_pos), .ref_neg(ref_neg), .drv_xp(drv_xp), .drv_xn(drv_xn),
    .drv_yp(drv_yp), .drv_yn(drv_yn), .ref_int_en(ref_int_en), .vbat_div_en(vbat_div_en),
    .res_8bit(res_8bit), .adc_pwr_keep(adc_pwr_keep));
  tad_host u_tad_host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Route byte above drive byte; unlisted codes keep panel and reference idle
  function automatic logic [15:0] exp_regs(input logic [7:0] c, input logic v);
    logic [3:0] d;
    logic [3:0] r;
    case (c[6:4])
      3'h1: begin d = 4'h3; r = 4'h5; end
      3'h3, 3'h4: begin d = 4'h6; r = 4'h6; end
      3'h5: begin d = 4'hC; r = 4'hA; end
      default: begin d = 4'h0; r = 4'h0; end
    endcase
    return {1'b0, IN_MAP[c[6:4]], c[2] ? 4'h0 : r, 2'h0, v, c[1], d};
  endfunction
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %0s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic run(input logic [3:0] a, input logic [7:0] c, input logic sa);
    logic [15:0] e;
    logic [7:0]  pins;
    sample_active <= sa;
    u_tad_host.put(a, c);
    if (a == 4'h0 && c[7]) cur = c;
    e = exp_regs(cur, sa && cur[6:4] == 3'h2);
    repeat (2) @(posedge clk);
    u_tad_host.get(4'h1, rv);
    check("route", rv, e[15:8]);
    u_tad_host.get(4'h2, rv);
    check("drive", rv, e[7:0]);
    check("mode", {6'h0, res_8bit, adc_pwr_keep}, {6'h0, cur[3], cur[0]});
    pins = {2'h0, vbat_div_en, ref_int_en, drv_xp, drv_xn, drv_yp, drv_yn};
    check("drive_pins", pins, e[7:0]);
    pins = {1'b0, in_sel, ref_pos, ref_neg};
    check("route_pins", pins, e[15:8]);
  endtask
  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out;
  end
  initial begin
    rst = 1'b1;
    sample_active = 1'b0;
    cur = tad_pkg::CTRL_RESET;
    lfsr = 8'h47;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    run(4'h0, 8'h84, 1'b0);
    for (int m = 0; m < 16; m++) begin
      lfsr = lfsr_next(lfsr);
      // Internal reference only with single-ended codes
      run(4'h0, {1'b1, m[2:0], lfsr[0], m[3], lfsr[1] & m[3], lfsr[2]}, 1'b1);
    end
    $display("test codes done");
    for (int k = 0; k < 24; k++) begin
      lfsr = lfsr_next(lfsr);
      run(4'h0, lfsr & {6'h3F, lfsr[2], 1'b1}, lfsr[3] ^ lfsr[6]);
    end
    $display("test random done");
    // Missing start bit and writes to read-only places must change nothing
    run(4'h0, 8'h7F, 1'b0);
    run(4'h1, 8'hFF, 1'b1);
    run(4'h2, 8'hFF, 1'b0);
    $display("test refused done");
    // Mid-run reset must return every output to its idle routing
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    cur = tad_pkg::CTRL_RESET;
    run(4'h0, 8'h7F, 1'b0);
    $display("test reset done");
    u_tad_host.get(4'hF, rv);
    check("unmapped", rv, 8'h00);
    check("resolution", 8'(tad_pkg::RESULT_BITS), 8'h0C);
    $display("test unmapped done");
    close_out;
  end
endmodule
bind tad_mux_ctrl tad_mux_ctrl_properties u_tad_mux_ctrl_properties (.clk(clk), .rst(rst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .sample_active(sample_active),
  .rdata(rdata), .in_sel(in_sel), .ref_pos(ref_pos), .ref_neg(ref_neg), .drv_xp(drv_xp),
  .drv_xn(drv_xn), .drv_yp(drv_yp), .drv_yn(drv_yn), .ref_int_en(ref_int_en),
  .vbat_div_en(vbat_div_en));
`default_nettype wire
